// *** core/sbsc_buf.sv ***
// sbsc_buf.sv: two-entry valid/ready buffer on the read data path
// assumes: one clock, synchronous active-high reset
`include "sbsc_params.svh"
module sbsc_buf #(
  parameter int W = 36
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] ent_q [0:1];
  logic         rd_q, wr_q;
  logic [1:0]   cnt_q;
  logic         push, pop;

  assign in_ready  = (cnt_q != 2'(`SBSC_BUF_DEPTH));
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = ent_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      ent_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
endmodule : sbsc_buf

// *** core/sbsc_ctrl.sv ***
// sbsc_ctrl.sv: control logic of a synchronous burst static ram
// assumes: inputs synchronous to ref_clk; testbench resolves io from enables
// Function
// - all sync inputs captured on rising edge of the single clock
// - burst order pin low: linear, high: interleaved (xor with load)
// - burst counter returns to loaded value on the fifth clock
// - two low address bits are low address and preset the counter
// - flow-through select low bypasses output register, else pipeline
// - sleep pin high enters standby power-down, low is normal
// - deselect select low gives dual cycle deselect, high single
// - floating mode pins: drive, deselect, output select high; sleep low
// - global store low writes every lane
// - byte store low: each low lane enable writes; all high is read
// - global and byte store high: read, all lanes output
// - all data io high impedance during any write
// - lanes three and four exist only in the 36-bit organisation
// - three deselect cases power down and float outputs; code only floats them, standby follows the sleep pin alone
// - chip select, qualifier, processor strobe low start read burst
// - controller strobe start: write if write decode true, else read
// - controller strobe high, advance low continue at next address
// - controller strobe and advance high suspend at current address
// - output enable acts asynchronously and only gates active drivers
// - qualifier true only with second enable high and third low
`include "sbsc_params.svh"
module sbsc_ctrl #(
  parameter int ADDR_W = `SBSC_ADDR_W,
  parameter int LANE_W = `SBSC_LANE_W,
  parameter int LANES  = `SBSC_LANES_X36
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  // mode pins, floating values applied by the surroundings
  input  wire logic                    linear_order_sel_n,
  input  wire logic                    flow_through_sel_n,
  input  wire logic                    sleep_request,
  input  wire logic                    single_deselect_sel,
  input  wire logic                    drive_strength_sel,
  // address and strobes
  input  wire logic [ADDR_W-1:0]       addr_in,
  input  wire logic                    chip_select_n,
  input  wire logic                    chip_select_hi,
  input  wire logic                    chip_select_low_n,
  input  wire logic                    proc_addr_strobe_n,
  input  wire logic                    ctrl_addr_strobe_n,
  input  wire logic                    burst_step_n,
  // write controls
  input  wire logic                    global_store_n,
  input  wire logic                    byte_store_n,
  input  wire logic [LANES-1:0]        lane_store_n,
  // output enable
  input  wire logic                    out_enable_n,
  // data io as three signals
  input  wire logic [LANES*LANE_W-1:0] byte_lane_io_i,
  output logic      [LANES*LANE_W-1:0] byte_lane_io_o,
  output logic      [LANES-1:0]        byte_lane_io_oe,
  // status
  output logic                         standby,
  output logic                         high_drive,
  // read data stream for a local consumer
  output logic                         rd_valid,
  input  wire logic                    rd_ready,
  output logic      [LANES*LANE_W-1:0] rd_data
);
  localparam int DW = LANES * LANE_W;
  localparam int BW = `SBSC_BURST_W;

  // decode of the sampled controls
  logic        qual;
  logic        desel, start_p, start_c, cont, susp;
  logic        wr_dec;
  logic [LANES-1:0] lane_wr;
  sbsc_pkg::sbsc_cycle_e cyc_d;

  // captured state
  logic [ADDR_W-1:0] base_q;
  logic [BW-1:0]     load_q, cnt_q, cnt_d;
  logic [ADDR_W-1:0] acc_addr;
  sbsc_pkg::sbsc_cycle_e cyc_q, cyc2_q;
  logic              active_q;
  logic              rd_flow_q, rd_pipe_q;
  logic              off_q, off2_q, off3_q, off4_q;
  logic [DW-1:0]     rdata_mem, dout_q;
  logic              buf_in_ready;

  assign qual = chip_select_hi && !chip_select_low_n;

  // write decode; upper lanes only present for the 36-bit width
  always_comb begin
    lane_wr = '0;
    if (!global_store_n) begin
      lane_wr = '1;
    end else if (!byte_store_n) begin
      lane_wr = ~lane_store_n;
    end
  end
  assign wr_dec = |lane_wr;

  // cycle classification, in truth-table priority
  always_comb begin
    desel   = 1'b0;
    start_p = 1'b0;
    start_c = 1'b0;
    cont    = 1'b0;
    susp    = 1'b0;
    if (!ctrl_addr_strobe_n && chip_select_n) begin
      desel = 1'b1;
    end else if (!chip_select_n && !qual && !proc_addr_strobe_n) begin
      desel = 1'b1;
    end else if (!chip_select_n && !qual && !ctrl_addr_strobe_n) begin
      desel = 1'b1;
    end else if (!chip_select_n && !proc_addr_strobe_n) begin
      start_p = 1'b1;
    end else if (!chip_select_n && !ctrl_addr_strobe_n) begin
      start_c = 1'b1;
    end else if (ctrl_addr_strobe_n && !burst_step_n
                 && (proc_addr_strobe_n || chip_select_n)) begin
      cont = 1'b1;
    end else if (ctrl_addr_strobe_n && burst_step_n) begin
      susp = 1'b1;
    end
  end

  always_comb begin
    if (start_p) begin
      cyc_d = sbsc_pkg::SBSC_READ;
    end else if ((start_c || ((cont || susp) && active_q)) && wr_dec) begin
      cyc_d = sbsc_pkg::SBSC_WRITE;
    end else if (start_c || ((cont || susp) && active_q)) begin
      cyc_d = sbsc_pkg::SBSC_READ;
    end else begin
      cyc_d = sbsc_pkg::SBSC_IDLE;
    end
  end

  // burst counter: linear adds, interleaved xors with the loaded value
  always_comb begin
    cnt_d = cnt_q;
    if (cont) begin
      if (!linear_order_sel_n) begin
        cnt_d = cnt_q + `SBSC_BURST_ONE;
      end else begin
        cnt_d = ((cnt_q ^ load_q) + `SBSC_BURST_ONE) ^ load_q;
      end
    end
  end

  // capture of address and counter on the rising edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      base_q <= '0;
      load_q <= `SBSC_BURST_ZERO;
      cnt_q  <= `SBSC_BURST_ZERO;
    end else if (start_p || start_c) begin
      base_q <= addr_in;
      load_q <= addr_in[BW-1:0];
      cnt_q  <= addr_in[BW-1:0];
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // address of the access in progress
  always_comb begin
    acc_addr = base_q;
    acc_addr[BW-1:0] = cnt_q;
  end

  // cycle pipeline; sleep forces idle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cyc_q    <= sbsc_pkg::SBSC_IDLE;
      cyc2_q   <= sbsc_pkg::SBSC_IDLE;
      active_q <= 1'b0;
    end else if (sleep_request) begin
      cyc_q    <= sbsc_pkg::SBSC_IDLE;
      cyc2_q   <= sbsc_pkg::SBSC_IDLE;
      active_q <= 1'b0;
    end else begin
      cyc_q    <= cyc_d;
      cyc2_q   <= cyc_q;
      if (desel) begin
        active_q <= 1'b0;
      end else if (start_p || start_c) begin
        active_q <= 1'b1;
      end
    end
  end

  // write lanes held for the array stage
  logic [LANES-1:0] lane_wr_q;
  logic [DW-1:0]    wdata_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lane_wr_q <= '0;
    end else if (cyc_d == sbsc_pkg::SBSC_WRITE && !sleep_request) begin
      lane_wr_q <= lane_wr;
    end else begin
      lane_wr_q <= '0;
    end
  end
  always_ff @(posedge ref_clk) begin
    wdata_q <= byte_lane_io_i;
  end

  // the array write uses the data that arrive a cycle after the command;
  // acc_addr still holds that command's address during that cycle
  sbsc_mem #(
    .ADDR_W (ADDR_W),
    .LANE_W (LANE_W),
    .LANES  (LANES)
  ) u_mem (
    .ref_clk (ref_clk),
    .addr    (acc_addr),
    .lane_wr (lane_wr_q),
    .wdata   (byte_lane_io_i),
    .rdata_q (rdata_mem)
  );

  // read valid flags: flow-through one stage, pipeline one more
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_flow_q <= 1'b0;
      rd_pipe_q <= 1'b0;
    end else begin
      rd_flow_q <= (cyc_q == sbsc_pkg::SBSC_READ);
      rd_pipe_q <= rd_flow_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    dout_q <= rdata_mem;
  end

  // output drive off after deselect: single at once, dual one edge later
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      off_q  <= 1'b1;
      off2_q <= 1'b1;
      off3_q <= 1'b1;
      off4_q <= 1'b1;
    end else begin
      off_q  <= desel || sleep_request;
      off2_q <= off_q;
      off3_q <= off2_q;
      off4_q <= off3_q;
    end
  end

  logic drv_read, drv_off, drv_data_sel;
  assign drv_data_sel = flow_through_sel_n;
  assign drv_read     = drv_data_sel ? rd_pipe_q : rd_flow_q;
  // off stages line up with the read data stage so a deselect never cuts a standing read
  assign drv_off      = drv_data_sel
                        ? (single_deselect_sel ? off3_q : (off3_q && off4_q))
                        : (single_deselect_sel ? off2_q : (off2_q && off3_q));

  always_comb begin
    byte_lane_io_o = drv_data_sel ? dout_q : rdata_mem;
    if (drv_read && !drv_off && !out_enable_n && cyc_q != sbsc_pkg::SBSC_WRITE) begin
      byte_lane_io_oe = '1;
    end else begin
      byte_lane_io_oe = '0;
    end
  end

  assign standby    = sleep_request;
  assign high_drive = !drive_strength_sel;

  // a stalled local consumer loses no word; overflow beyond two is dropped
  sbsc_buf #(
    .W (DW)
  ) u_buf (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (drv_read),
    .in_ready  (buf_in_ready),
    .in_data   (byte_lane_io_o),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );
  logic unused_ok;
  assign unused_ok = buf_in_ready ^ (|wdata_q) ^ (cyc2_q == sbsc_pkg::SBSC_IDLE);
endmodule : sbsc_ctrl

// *** core/sbsc_mem.sv ***
// sbsc_mem.sv: storage array with per-lane write and registered read data
// assumes: one clock; read and write share one address per cycle
`include "sbsc_params.svh"
module sbsc_mem #(
  parameter int ADDR_W = `SBSC_ADDR_W,
  parameter int LANE_W = `SBSC_LANE_W,
  parameter int LANES  = `SBSC_LANES_X36
) (
  // clock
  input  wire logic                      ref_clk,
  // access
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [LANES-1:0]          lane_wr,
  input  wire logic [LANES*LANE_W-1:0]   wdata,
  output logic      [LANES*LANE_W-1:0]   rdata_q
);
  logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge ref_clk) begin
      if (lane_wr[g]) begin
        mem[addr][g*LANE_W +: LANE_W] <= wdata[g*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    rdata_q <= mem[addr];
  end
endmodule : sbsc_mem

// *** core/sbsc_params.svh ***
// sbsc_params.svh: constants for the synchronous burst sram control block
// assumes: included by bare name from the design modules
`ifndef SBSC_PARAMS_SVH
`define SBSC_PARAMS_SVH
`define SBSC_ADDR_W       20
`define SBSC_LANE_W       9
`define SBSC_LANES_X36    4
`define SBSC_BURST_W      2
`define SBSC_BURST_ONE    2'h1
`define SBSC_BURST_ZERO   2'h0
`define SBSC_BUF_DEPTH    2
`define SBSC_CLK_PERIOD_NS 4
`endif

// *** core/sbsc_pkg.sv ***
// sbsc_pkg.sv: types shared by the burst sram control modules
// assumes: nothing beyond the params header
package sbsc_pkg;
  typedef enum logic [1:0] {
    SBSC_IDLE  = 2'b00,
    SBSC_READ  = 2'b01,
    SBSC_WRITE = 2'b10
  } sbsc_cycle_e;
endpackage : sbsc_pkg

// *** verif/sbsc_checker.sv ***
// sbsc_checker.sv: port assertions for the burst sram control block
// assumes: bound into sbsc_ctrl; mode pins steady around commands
module sbsc_checker #(
  parameter int LANES  = 4,
  parameter int LANE_W = 9
) (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    sys_rst,
  // watched inputs
  input wire logic                    flow_through_sel_n,
  input wire logic                    sleep_request,
  input wire logic                    drive_strength_sel,
  input wire logic                    chip_select_n,
  input wire logic                    chip_select_hi,
  input wire logic                    chip_select_low_n,
  input wire logic                    proc_addr_strobe_n,
  input wire logic                    ctrl_addr_strobe_n,
  input wire logic                    global_store_n,
  input wire logic                    byte_store_n,
  input wire logic [LANES-1:0]        lane_store_n,
  input wire logic                    out_enable_n,
  input wire logic                    rd_ready,
  // watched outputs
  input wire logic [LANES-1:0]        byte_lane_io_oe,
  input wire logic                    standby,
  input wire logic                    high_drive,
  input wire logic                    rd_valid,
  input wire logic [LANES*LANE_W-1:0] rd_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic q, wdec, rd_go, wr_on, dsel;
  assign q     = chip_select_hi && !chip_select_low_n;
  assign wdec  = !global_store_n || (!byte_store_n && !(&lane_store_n));
  assign rd_go = !chip_select_n && q && !sleep_request
                 && (!proc_addr_strobe_n || (!ctrl_addr_strobe_n && !wdec));
  // a continue with both strobes high writes too; a start needs the qualifier
  assign wr_on = wdec && (chip_select_n ? ctrl_addr_strobe_n
                 : (proc_addr_strobe_n && (ctrl_addr_strobe_n || q)));
  assign dsel  = (chip_select_n && !ctrl_addr_strobe_n)
                 || (!chip_select_n && !q && !(proc_addr_strobe_n && ctrl_addr_strobe_n));
  a_standby_pin: assert property (standby == sleep_request)
    else $error("standby differs from sleep pin");
  a_drive_pin: assert property (high_drive == !drive_strength_sel)
    else $error("drive strength output wrong");
  a_oe_gate: assert property (out_enable_n |-> byte_lane_io_oe == '0)
    else $error("driving with output enable high");
  a_lanes_same: assert property (byte_lane_io_oe == '0 || byte_lane_io_oe == '1)
    else $error("lanes not driven together");
  a_flow_read: assert property (rd_go && !flow_through_sel_n |->
    ##[2:3] (out_enable_n || byte_lane_io_oe == '1)) else $error("flow read not driven");
  a_pipe_read: assert property (rd_go && flow_through_sel_n |->
    ##[3:4] (out_enable_n || byte_lane_io_oe == '1)) else $error("pipeline read not driven");
  a_write_float: assert property (wr_on [*3] |-> ##2 byte_lane_io_oe == '0)
    else $error("driving during writes");
  a_deselect_off: assert property (dsel [*5] |-> ##1 byte_lane_io_oe == '0)
    else $error("driving after deselect");
  a_sleep_off: assert property (sleep_request [*5] |-> byte_lane_io_oe == '0)
    else $error("driving in standby");
  a_valid_held: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("stalled read word lost");
endmodule : sbsc_checker

bind sbsc_ctrl sbsc_checker #(.LANES(LANES), .LANE_W(LANE_W)) u_chk (.*);

// *** verif/sbsc_host.sv ***
// sbsc_host.sv: far-side host model that resolves the shared data wire
// assumes: the bench says when the host owns the wire for write data
module sbsc_host (
  // clock
  input  wire logic        ref_clk,
  // wire sides
  input  wire logic [35:0] io_o,
  input  wire logic [3:0]  io_oe,
  input  wire logic        wr_en,
  input  wire logic [35:0] wr_data,
  output logic      [35:0] io_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] last_q;
  always_ff @(posedge ref_clk) begin
    last_q <= io_i;
  end
  // no pull on data lines: a floating lane shows the inverse of its last value
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      io_i[l*9+:9] = io_oe[l] ? io_o[l*9+:9] : (wr_en ? wr_data[l*9+:9] : ~last_q[l*9+:9]);
    end
  end
endmodule : sbsc_host

// *** verif/tb_top.sv ***
// tb_top.sv: self-checking bench for the burst sram control block
// assumes: sbsc_host resolves the data wire; reads return on the rd stream
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, sys_rst, linear_order_sel_n, flow_through_sel_n, sleep_request;
  logic        single_deselect_sel, drive_strength_sel, chip_select_n, chip_select_hi;
  logic        chip_select_low_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n;
  logic        global_store_n, byte_store_n, out_enable_n, rd_ready, rd_valid;
  logic        standby, high_drive, wr_en, pend_w;
  logic [3:0]  lane_store_n, byte_lane_io_oe;
  logic [19:0] addr_in;
  logic [35:0] byte_lane_io_i, byte_lane_io_o, rd_data, wr_data, pend_d, mem [int];
  logic [35:0] exp_q [$];
  logic [17:0] base;
  logic [1:0]  ld, k;
  int          n_mismatch, cmp_count;
  sbsc_ctrl dut (.*);
  sbsc_host u_host (.ref_clk(ref_clk), .io_o(byte_lane_io_o), .io_oe(byte_lane_io_oe),
                    .wr_en(wr_en), .wr_data(wr_data), .io_i(byte_lane_io_i));
  task automatic check(input logic [35:0] s, input logic [35:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // c = {cs_n, proc_addr_strobe_n_n, ctrl_addr_strobe_n_n, adv_n, gw_n, bw_n}; notes the expected result
  task automatic cyc(input logic [5:0] c, input logic [3:0] ln, input logic [35:0] d);
    logic        st, wd;
    logic [19:0] a;
    logic [35:0] m;
    @(negedge ref_clk);
    {chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
     global_store_n, byte_store_n} = c;
    st           = !c[5] && !(c[4] && c[3]);
    wd           = (!c[1] || (!c[0] && ln != 4'hf)) && !(st && !c[4]);
    lane_store_n = ln;
    addr_in      = st ? {base, ld} : 20'($urandom);
    wr_en        = pend_w;
    wr_data      = pend_d;
    pend_w       = 1'b0;
    if (sleep_request || (c[5] && !c[3]) || (st && !(chip_select_hi && !chip_select_low_n)))
      return;
    if (st) k = 2'h0;
    else if (!c[2]) k = k + 2'h1;
    a = {base, linear_order_sel_n ? ld ^ k : ld + k};
    m = {{9{!ln[3]}}, {9{!ln[2]}}, {9{!ln[1]}}, {9{!ln[0]}}} | {36{!c[1]}};
    if (!wd) exp_q.push_back(mem[a]);
    else begin
      pend_w = 1'b1;
      pend_d = d;
      mem[a] = (mem[a] & ~m) | (d & m);
    end
  endtask : cyc
  always @(posedge ref_clk) begin
    if (!sys_rst && rd_valid === 1'b1 && rd_ready === 1'b1) begin
      check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 36'hx);
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    {linear_order_sel_n, flow_through_sel_n, sleep_request, single_deselect_sel,
     drive_strength_sel} = 5'b11011;
    {chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 4'hf;
    {global_store_n, byte_store_n, chip_select_hi, chip_select_low_n} = 4'he;
    {out_enable_n, rd_ready, wr_en, pend_w, sys_rst} = 5'b01001;
    {lane_store_n, addr_in, wr_data, pend_d, base, ld, k} = '0;
    void'($urandom(32'haa640682));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'b0;
    for (int md = 0; md < 8; md++) begin
      {linear_order_sel_n, flow_through_sel_n, single_deselect_sel} = 3'(md);
      drive_strength_sel = 1'($urandom);
      base = 18'($urandom);
      ld   = 2'($urandom);
      cyc(6'b010101, 4'($urandom), 36'($urandom));
      check(36'(high_drive), 36'(!drive_strength_sel));
      repeat (3) cyc(6'b011001, 4'($urandom), 36'($urandom));
      cyc(6'b010110, 4'($urandom % 15), 36'($urandom));
      repeat (3) cyc(6'b011010, 4'($urandom % 15), 36'($urandom));
      repeat (2) cyc(6'b110111, 4'hf, 36'h0);
      cyc(md[2] ? 6'b001101 : 6'b010111, 4'h0, 36'h0);
      cyc(6'b101011, 4'h0, 36'h0);
      cyc(6'b011110, 4'hf, 36'h0);
      repeat (3) cyc(6'b011011, 4'h0, 36'h0);
      repeat (6) cyc(6'b110111, 4'hf, 36'h0);
      $display("test mode %0d done", md);
    end
    // qualifier false, then standby: nothing may start
    out_enable_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      {chip_select_hi, chip_select_low_n} = 2'(i == 2 ? 3 : i);
      cyc(6'b001111, 4'hf, 36'h0);
      cyc(6'b010111, 4'hf, 36'h0);
    end
    {chip_select_hi, chip_select_low_n, sleep_request} = 3'b101;
    repeat (2) cyc(6'b110111, 4'hf, 36'h0);
    cyc(6'b001111, 4'hf, 36'h0);
    check(36'(standby), 36'h1);
    repeat (5) cyc(6'b110111, 4'hf, 36'h0);
    {sleep_request, out_enable_n} = 2'b00;
    $display("test deselect and standby done");
    // stall the consumer while two reads fill the buffer
    rd_ready = 1'b0;
    cyc(6'b001111, 4'hf, 36'h0);
    cyc(6'b011011, 4'h0, 36'h0);
    repeat (6) cyc(6'b110111, 4'hf, 36'h0);
    rd_ready = 1'b1;
    repeat (6) cyc(6'b110111, 4'hf, 36'h0);
    check(36'(exp_q.size()), 36'h0);
    $display("test stall done");
    end_sim();
  end
endmodule : tb_top
